// ---- inc/fsp_pkg.sv ----
// Purpose: shared constants, types and ecc functions of the flash self-program controller
// Assumes: 40 MHz clock, 32-bit apb, 24-bit program words stored in pairs
// Notes: a stored pair is 48 data bits plus 7 check bits
`default_nettype none
package fsp_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] FSP_CTRL_OFS = 8'h00;
	localparam logic [7:0] FSP_KEY_OFS = 8'h04;
	localparam logic [7:0] FSP_ADRL_OFS = 8'h08;
	localparam logic [7:0] FSP_ADRH_OFS = 8'h0c;
	localparam logic [7:0] FSP_SRC_OFS = 8'h10;
	localparam logic [7:0] FSP_PAGE_OFS = 8'h14;
	localparam logic [7:0] FSP_ECC_OFS = 8'h18;
	// ==========================================================
	// flash_control_reg fields
	localparam int FSP_CTRL_START = 15;
	localparam int FSP_CTRL_WREN = 14;
	localparam int FSP_CTRL_SEQERR = 13;
	localparam int FSP_CTRL_CMPR = 9;
	localparam logic [3:0] FSP_OP_DWORD = 4'h1;
	localparam logic [3:0] FSP_OP_ROW = 4'h2;
	localparam logic [3:0] FSP_OP_PAGE = 4'h3;
	localparam logic [3:0] FSP_OP_PANEL = 4'h4;
	// ecc register fields
	localparam int FSP_ECC_FLAG = 0;
	localparam int FSP_ECC_EN = 1;
	localparam int FSP_ECC_PRI_LSB = 2;
	// ==========================================================
	// key values, geometry and timing
	localparam logic [7:0] FSP_KEY1 = 8'h55;
	localparam logic [7:0] FSP_KEY2 = 8'haa;
	localparam logic [1:0] FSP_KEY_ARMED = 2'h2;
	localparam logic [5:0] FSP_ROW_PAIRS = 6'h20;
	localparam int FSP_ROW_ALIGN = 7;
	localparam int FSP_PAGE_ALIGN = 10;
	localparam logic [15:0] FSP_PROG_CYC = 16'h0040;
	localparam logic [15:0] FSP_ERASE_CYC = 16'h0100;
	// flash macro commands
	localparam logic [1:0] FSP_FA_READ = 2'h0;
	localparam logic [1:0] FSP_FA_PROG = 2'h1;
	localparam logic [1:0] FSP_FA_PAGE = 2'h2;
	localparam logic [1:0] FSP_FA_PANEL = 2'h3;

	typedef enum logic [4:0] {
		FSP_IDLE = 5'h01,
		FSP_RD = 5'h02,
		FSP_FETCH = 5'h04,
		FSP_PROG = 5'h08,
		FSP_ERASE = 5'h10
	} fsp_state_t;

	// ==========================================================
	// hamming check bits: six position parities plus an overall parity
	function automatic logic [6:0] fsp_encode(input logic [47:0] d);
		logic [6:0] c;
		int k;
		c = 7'h00;
		k = 0;
		for (int p = 1; p < 55; p++) begin
			if ((p & (p - 1)) != 0) begin
				for (int b = 0; b < 6; b++) begin
					if (p[b])
						c[b] = c[b] ^ d[k];
				end
				k++;
			end
		end
		c[6] = ^{d, c[5:0]};
		return c;
	endfunction

	// returns {double, single, corrected data}
	function automatic logic [49:0] fsp_decode(input logic [54:0] w);
		logic [6:0] c;
		logic [5:0] syn;
		logic [47:0] d;
		logic odd;
		int k;
		d = w[47:0];
		c = fsp_encode(d);
		syn = c[5:0] ^ w[53:48];
		odd = ^w;
		k = 0;
		for (int p = 1; p < 55; p++) begin
			if ((p & (p - 1)) != 0) begin
				if (odd && syn == p[5:0])
					d[k] = ~d[k];
				k++;
			end
		end
		// odd weight means one flip, even weight with a syndrome means two
		if (!odd && syn != 6'h00)
			return {1'b1, 1'b0, w[47:0]};
		return {1'b0, odd, d};
	endfunction

	// shapes a 24-bit word into table read data
	function automatic logic [15:0] fsp_tbl_rd(input logic [23:0] w, input logic high,
		input logic byte_m, input logic bsel);
		if (high)
			return (byte_m && bsel) ? 16'h0000 : {8'h00, w[23:16]};
		if (byte_m)
			return {8'h00, bsel ? w[15:8] : w[7:0]};
		return w[15:0];
	endfunction
endpackage
`default_nettype wire

// ---- design/fsp_flash_ctrl.sv ----
// Purpose: run-time self-program controller with table access, row fetch and ecc
// Assumes: core holds a table request until ack; flash macro answers reads while the read pulse stands
// Notes: stall_o freezes the core for the whole self-timed operation
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: target address is table_page_reg low byte above the 16-bit effective address.
// RULE2: low table read and write reach bits 15..0, word or byte mode.
// RULE3: high table read and write reach bits 23..16, word or byte mode.
// RULE4: a programming row holds 64 instructions, 192 bytes.
// RULE5: page erase clears eight rows, 512 instructions, at once.
// RULE6: pages and rows align to their own size; low address bits ignored.
// RULE7: software fills two write latches; start bit then programs them.
// RULE8: double-word targets sit on every other word address.
// RULE9: row program fetches RAM data, fills latches, advances source and flash address.
// RULE10: control bit 9 selects compressed or uncompressed row data.
// RULE11: compressed: second instruction top byte is second RAM word upper byte.
// RULE12: start bit launches the operation; hardware clears it when done.
// RULE13: core is held stalled until the operation completes.
// RULE14: no erase or program starts without the unlock key sequence.
// RULE15: software puts two no-ops after the start.
// RULE16: software erases the page before reprogramming any word.
// RULE17: each write stores 48 data bits plus 7 hidden hamming bits.
// RULE18: error correction is always on; no control bit disables it.
// RULE19: read-back single-bit error is corrected and sets the error flag.
// RULE20: double-bit error returns raw data and raises a hard trap.
// RULE21: single-bit interrupt reaches core only when enabled, at its priority.
// RULE22: no error address latch or error counter exists.
// RULE23: key is 0x55 then 0xaa on consecutive writes.
// RULE24: high and low address registers form the 24-bit flash address.
// RULE25: control op field picks page erase, word, row or panel erase.
// RULE26: one accepted key sequence permits exactly one start.
module fsp_flash_ctrl import fsp_pkg::*; #(
	parameter logic [15:0] PROG_CYC = FSP_PROG_CYC,
	parameter logic [15:0] ERASE_CYC = FSP_ERASE_CYC
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic tbl_req_i,
	input wire logic tbl_write_i,
	input wire logic tbl_high_i,
	input wire logic tbl_byte_i,
	input wire logic [15:0] tbl_ea_i,
	input wire logic [15:0] tbl_wdata_i,
	output logic [15:0] tbl_rdata_o,
	output logic tbl_ack_o,
	output logic stall_o,
	output logic ram_req_o,
	output logic [15:0] ram_addr_o,
	input wire logic ram_ack_i,
	input wire logic [15:0] ram_rdata_i,
	output logic fa_en_o,
	output logic [1:0] fa_op_o,
	output logic [21:0] fa_addr_o,
	output logic [54:0] fa_wdata_o,
	input wire logic [54:0] fa_rdata_i,
	output logic sbe_irq_o,
	output logic [2:0] sbe_irq_pri_o,
	output logic hard_trap_o
);
	// ==========================================================
	// state
	typedef struct packed {
		fsp_state_t st;
		logic start;
		logic wren;
		logic seq_err;
		logic cmpr;
		logic [3:0] op;
		logic [1:0] key;
		logic [23:0] addr;
		logic [15:0] src;
		logic [7:0] page;
		logic sbe_flag;
		logic sbe_en;
		logic [2:0] sbe_pri;
		logic [47:0] lat;
		logic [5:0] cnt;
		logic [1:0] sub;
		logic [15:0] tmr;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic tbl_ack;
		logic [15:0] tbl_rdata;
		logic stall;
		logic ram_req;
		logic fa_en;
		logic [1:0] fa_op;
		logic [21:0] fa_addr;
		logic [54:0] fa_wdata;
		logic irq;
		logic trap;
	} fsp_regs_t;

	fsp_regs_t q;
	fsp_regs_t next_q;
	logic [23:0] tgt;
	logic [49:0] dec;
	logic [23:0] rd_w;
	logic wr_acc;
	logic sbe_set;

	assign tgt = {q.page, tbl_ea_i}; // RULE1
	assign wr_acc = psel_i && penable_i && q.pready && pwrite_i;

	// ==========================================================
	// next-state logic
	always_comb begin
		next_q = q;
		next_q.pready = 1'b0;
		next_q.pslverr = 1'b0;
		next_q.tbl_ack = 1'b0;
		next_q.fa_en = 1'b0;
		next_q.trap = 1'b0;
		sbe_set = 1'b0;
		dec = fsp_decode(fa_rdata_i); // RULE18
		rd_w = tgt[1] ? dec[47:24] : dec[23:0];

		// apb: answer in the first access cycle, reads sampled at setup
		if (psel_i && !penable_i) begin
			next_q.pready = 1'b1;
			next_q.prdata = 32'h0000_0000;
			case (paddr_i)
				FSP_CTRL_OFS: next_q.prdata = {16'h0000, q.start, q.wren, q.seq_err, 3'h0,
					q.cmpr, 5'h00, q.op};
				FSP_KEY_OFS: next_q.prdata = 32'h0000_0000; // key reads as zero
				FSP_ADRL_OFS: next_q.prdata = {16'h0000, q.addr[15:0]};
				FSP_ADRH_OFS: next_q.prdata = {24'h000000, q.addr[23:16]};
				FSP_SRC_OFS: next_q.prdata = {16'h0000, q.src};
				FSP_PAGE_OFS: next_q.prdata = {24'h000000, q.page};
				FSP_ECC_OFS: next_q.prdata = {27'h0000000, q.sbe_pri, q.sbe_en, q.sbe_flag};
				default: next_q.pslverr = 1'b1;
			endcase
		end

		// register writes; any write but a key write, or a control write without start once armed, breaks the key sequence
		if (wr_acc) begin
			next_q.key = 2'h0; // RULE23
			case (paddr_i)
				FSP_CTRL_OFS: begin
					if (!q.start) begin
						next_q.wren = pwdata_i[FSP_CTRL_WREN];
						next_q.seq_err = pwdata_i[FSP_CTRL_SEQERR];
						next_q.cmpr = pwdata_i[FSP_CTRL_CMPR]; // RULE10
						next_q.op = pwdata_i[3:0]; // RULE25
						if (!pwdata_i[FSP_CTRL_START] && q.key == FSP_KEY_ARMED)
							next_q.key = q.key;
					end
				end
				FSP_KEY_OFS: begin
					if (pwdata_i[7:0] == FSP_KEY1)
						next_q.key = 2'h1;
					else if (pwdata_i[7:0] == FSP_KEY2 && q.key == 2'h1)
						next_q.key = FSP_KEY_ARMED; // RULE23
				end
				FSP_ADRL_OFS: begin
					if (!q.start)
						next_q.addr[15:0] = pwdata_i[15:0]; // RULE24
				end
				FSP_ADRH_OFS: begin
					if (!q.start)
						next_q.addr[23:16] = pwdata_i[7:0]; // RULE24
				end
				FSP_SRC_OFS: begin
					if (!q.start)
						next_q.src = pwdata_i[15:0];
				end
				FSP_PAGE_OFS: next_q.page = pwdata_i[7:0];
				FSP_ECC_OFS: begin
					if (pwdata_i[FSP_ECC_FLAG])
						next_q.sbe_flag = 1'b0; // write one to clear
					next_q.sbe_en = pwdata_i[FSP_ECC_EN];
					next_q.sbe_pri = pwdata_i[FSP_ECC_PRI_LSB +: 3];
				end
				default: ;
			endcase
		end

		// start request: needs write enable, the armed key and a known op
		if (wr_acc && paddr_i == FSP_CTRL_OFS && pwdata_i[FSP_CTRL_START] && !q.start) begin
			next_q.key = 2'h0; // RULE26
			if (pwdata_i[FSP_CTRL_WREN] && q.key == FSP_KEY_ARMED && q.st == FSP_IDLE &&
				pwdata_i[3:0] >= FSP_OP_DWORD && pwdata_i[3:0] <= FSP_OP_PANEL) begin // RULE14
				next_q.start = 1'b1; // RULE12
				next_q.stall = 1'b1; // RULE13
				next_q.fa_op = FSP_FA_PROG;
				next_q.fa_addr = q.addr[23:2]; // RULE8
				case (pwdata_i[3:0])
					FSP_OP_DWORD: begin
						next_q.st = FSP_PROG; // RULE7
						next_q.fa_en = 1'b1;
						next_q.fa_wdata = {fsp_encode(q.lat), q.lat}; // RULE17
						next_q.tmr = PROG_CYC;
					end
					FSP_OP_ROW: begin
						next_q.st = FSP_FETCH; // RULE9
						next_q.addr[FSP_ROW_ALIGN-1:0] = '0; // RULE6
						next_q.cnt = 6'h00;
						next_q.sub = 2'h0;
						next_q.ram_req = 1'b1;
					end
					default: begin
						next_q.st = FSP_ERASE; // RULE5
						next_q.fa_en = 1'b1;
						next_q.fa_op = (pwdata_i[3:0] == FSP_OP_PAGE) ? FSP_FA_PAGE : FSP_FA_PANEL;
						next_q.fa_addr = {q.addr[23:FSP_PAGE_ALIGN], 8'h00}; // RULE6
						next_q.tmr = ERASE_CYC;
					end
				endcase
			end else begin
				next_q.seq_err = 1'b1; // RULE14
			end
		end

		// ==========================================================
		// sequencer
		case (q.st)
			FSP_IDLE: begin
				if (tbl_req_i && !q.tbl_ack && !q.start) begin
					if (q.page[7]) begin
						// configuration space: the two write latches
						next_q.tbl_ack = 1'b1;
						next_q.tbl_rdata = fsp_tbl_rd(tgt[1] ? q.lat[47:24] : q.lat[23:0],
							tbl_high_i, tbl_byte_i, tgt[0]);
						if (tbl_write_i) begin
							if (tbl_high_i && !(tbl_byte_i && tgt[0]))
								next_q.lat[{tgt[1], 3'h0} * 3 + 16 +: 8] = tbl_wdata_i[7:0]; // RULE3
							else if (!tbl_high_i && tbl_byte_i)
								next_q.lat[{tgt[1], 3'h0} * 3 + {tgt[0], 3'h0} +: 8] =
									tbl_wdata_i[7:0]; // RULE2
							else if (!tbl_high_i)
								next_q.lat[{tgt[1], 3'h0} * 3 +: 16] = tbl_wdata_i; // RULE2
						end
					end else if (tbl_write_i) begin
						next_q.tbl_ack = 1'b1; // user space only changes through the latches
					end else begin
						next_q.st = FSP_RD;
						next_q.fa_en = 1'b1;
						next_q.fa_op = FSP_FA_READ;
						next_q.fa_addr = tgt[23:2];
					end
				end
			end
			FSP_RD: begin
				// single flips are corrected, double flips return raw data
				next_q.st = FSP_IDLE;
				next_q.tbl_ack = 1'b1;
				next_q.tbl_rdata = fsp_tbl_rd(rd_w, tbl_high_i, tbl_byte_i, tgt[0]); // RULE2 RULE3
				sbe_set = dec[48]; // RULE19
				next_q.trap = dec[49]; // RULE20
			end
			FSP_FETCH: begin
				if (ram_ack_i) begin
					next_q.src = q.src + 16'h0002; // RULE9
					case (q.sub)
						2'h0: next_q.lat[15:0] = ram_rdata_i;
						2'h1: begin
							next_q.lat[23:16] = ram_rdata_i[7:0];
							if (q.cmpr)
								next_q.lat[47:40] = ram_rdata_i[15:8]; // RULE11
						end
						2'h2: next_q.lat[39:24] = ram_rdata_i;
						default: next_q.lat[47:40] = ram_rdata_i[7:0];
					endcase
					next_q.sub = q.sub + 2'h1;
					if (q.sub == (q.cmpr ? 2'h2 : 2'h3)) begin // RULE10
						next_q.ram_req = 1'b0;
						next_q.st = FSP_PROG;
						next_q.tmr = PROG_CYC;
					end
				end
			end
			FSP_PROG: begin
				// the latched pair is issued on the first cycle of the timed wait
				if (q.tmr == PROG_CYC && q.op == FSP_OP_ROW) begin
					next_q.fa_en = 1'b1;
					next_q.fa_op = FSP_FA_PROG;
					next_q.fa_addr = q.addr[23:2];
					next_q.fa_wdata = {fsp_encode(q.lat), q.lat}; // RULE17
				end
				next_q.tmr = q.tmr - 16'h0001;
				if (q.tmr == 16'h0001) begin
					if (q.op == FSP_OP_ROW && q.cnt != FSP_ROW_PAIRS - 6'h01) begin
						next_q.addr = q.addr + 24'h000004; // RULE9
						next_q.cnt = q.cnt + 6'h01; // RULE4
						next_q.sub = 2'h0;
						next_q.ram_req = 1'b1;
						next_q.st = FSP_FETCH;
					end else begin
						next_q.st = FSP_IDLE;
						next_q.start = 1'b0; // RULE12
						next_q.stall = 1'b0; // RULE13
					end
				end
			end
			FSP_ERASE: begin
				next_q.tmr = q.tmr - 16'h0001;
				if (q.tmr == 16'h0001) begin
					next_q.st = FSP_IDLE;
					next_q.start = 1'b0; // RULE12
					next_q.stall = 1'b0; // RULE13
				end
			end
			default: next_q.st = FSP_IDLE;
		endcase

		// the flag alone records errors; hardware set beats software clear
		if (sbe_set)
			next_q.sbe_flag = 1'b1; // RULE19 RULE22
		next_q.irq = next_q.sbe_flag && next_q.sbe_en; // RULE21
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '0;
			q.st <= FSP_IDLE;
		end else begin
			q <= next_q;
		end
	end

	assign prdata_o = q.prdata;
	assign pready_o = q.pready;
	assign pslverr_o = q.pslverr;
	assign tbl_rdata_o = q.tbl_rdata;
	assign tbl_ack_o = q.tbl_ack;
	assign stall_o = q.stall;
	assign ram_req_o = q.ram_req;
	assign ram_addr_o = q.src;
	assign fa_en_o = q.fa_en;
	assign fa_op_o = q.fa_op;
	assign fa_addr_o = q.fa_addr;
	assign fa_wdata_o = q.fa_wdata;
	assign sbe_irq_o = q.irq;
	assign sbe_irq_pri_o = q.sbe_pri;
	assign hard_trap_o = q.trap;

	// ==========================================================
	// assertions
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_start_wr;
		wr_acc && paddr_i == FSP_CTRL_OFS && pwdata_i[FSP_CTRL_START] && !q.start;
	endsequence

	a_apb_ready_next: assert property (@(posedge clk_i) disable iff (!resetn_i) // apb port design decision
		s_setup |=> pready_o) else $error("pready not raised after setup");
	a_start_needs_key: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE14
		$rose(q.start) |-> $past(q.key) == FSP_KEY_ARMED) else $error("start without key");
	a_key_single_use: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE26
		s_start_wr |=> q.key == 2'h0) else $error("key still armed after start");
	a_stall_tracks_busy: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE13
		stall_o == q.start) else $error("stall differs from start bit");
	a_prog_parity: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE17
		fa_en_o && fa_op_o == FSP_FA_PROG |-> fa_wdata_o[54:48] == fsp_encode(fa_wdata_o[47:0]))
		else $error("stored check bits wrong");
	a_erase_align: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE6
		fa_en_o && fa_op_o == FSP_FA_PAGE |-> fa_addr_o[7:0] == 8'h00) else $error("erase unaligned");
	a_read_addr: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE1
		q.st == FSP_RD |-> fa_addr_o == tgt[23:2] ##1 tbl_ack_o) else $error("table read address");
	a_irq_gate: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE21
		sbe_irq_o |-> q.sbe_en && q.sbe_flag) else $error("irq while masked");
	a_trap_raw: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE20
		hard_trap_o |-> !$rose(q.sbe_flag)) else $error("double error set single flag");
	a_row_pairs: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE4
		q.st == FSP_FETCH |-> q.cnt < FSP_ROW_PAIRS) else $error("row pair count overrun");
endmodule
`default_nettype wire

// ---- tb/fsp_far_model.sv ----
// Purpose: data ram and flash macro standing behind the self-program controller
// Assumes: flash read data stands during the read pulse, which is when the controller takes it
// Notes: flip_i corrupts read-back so that the ecc path can be exercised
`timescale 1ns/1ps
`default_nettype none
module fsp_far_model import fsp_pkg::*; (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ram_req_i,
	input wire logic [15:0] ram_addr_i,
	output logic ram_ack_o,
	output logic [15:0] ram_rdata_o,
	input wire logic fa_en_i,
	input wire logic [1:0] fa_op_i,
	input wire logic [21:0] fa_addr_i,
	input wire logic [54:0] fa_wdata_i,
	output logic [54:0] fa_rdata_o,
	input wire logic [54:0] flip_i
);
	logic [54:0] mem [1024];
	logic [54:0] stale;
	logic [1:0] wait_cnt;
	// flash reads answer while the read pulse stands, so the controller latches them on its next edge
	assign fa_rdata_o = (fa_en_i && fa_op_i == FSP_FA_READ) ? mem[fa_addr_i[9:0]] ^ flip_i : stale;
	// ==========================================================
	// ram waits 0..3 cycles by address; idle data toggles so stale values never match
	// the cell array folds pair indices onto ten bits, which the tested addresses never alias
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ram_ack_o <= 1'b0;
			wait_cnt <= 2'h0;
			ram_rdata_o <= 16'h0000;
			stale <= 55'h0;
			for (int i = 0; i < 1024; i++)
				mem[i] <= 55'h0;
		end else begin
			ram_ack_o <= 1'b0;
			ram_rdata_o <= ~ram_rdata_o;
			wait_cnt <= (ram_req_i && !ram_ack_o) ? wait_cnt + 2'h1 : 2'h0;
			if (ram_req_i && !ram_ack_o && wait_cnt == ram_addr_i[2:1]) begin
				ram_ack_o <= 1'b1;
				ram_rdata_o <= ram_addr_i ^ 16'h5a3c;
			end
			stale <= ~stale;
			// flash macro: 55-bit cells, erased cells read as zero
			if (fa_en_i) begin
				case (fa_op_i)
					FSP_FA_PROG: mem[fa_addr_i[9:0]] <= fa_wdata_i;
					FSP_FA_PAGE: for (int i = 0; i < 256; i++) mem[{fa_addr_i[9:8], i[7:0]}] <= 55'h0;
					FSP_FA_PANEL: for (int i = 0; i < 1024; i++) mem[i] <= 55'h0;
					default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/flash_self_program_ecc_tb.sv ----
// Purpose: self-checking bench of the flash self-program controller
// Assumes: short program and erase counts; register layout from the package
// Notes: table and apb requests are held until their answer, released after it
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_ecc_tb;
	import fsp_pkg::*;
	localparam logic [15:0] P_CYC = 16'h0004;
	localparam logic [15:0] E_CYC = 16'h0006;
	typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] x; logic e;} fsp_reg_row_t;
	typedef struct packed {logic hi; logic bm; logic [15:0] ea; logic [15:0] x;} fsp_tbl_row_t;
	fsp_reg_row_t rr [8] = '{'{FSP_PAGE_OFS, 32'h1ff, 32'hff, 1'b0}, '{FSP_ADRH_OFS, 32'h1a5, 32'ha5, 1'b0},
		'{FSP_ADRL_OFS, 32'h12345, 32'h2345, 1'b0}, '{FSP_SRC_OFS, 32'hbeef, 32'hbeef, 1'b0},
		'{FSP_ECC_OFS, 32'h1e, 32'h1e, 1'b0}, '{FSP_KEY_OFS, 32'h12, 32'h0, 1'b0},
		'{FSP_CTRL_OFS, 32'h203, 32'h203, 1'b0}, '{8'h1c, 32'h0, 32'h0, 1'b1}};
	fsp_tbl_row_t tr [7] = '{'{1'b0, 1'b0, 16'h4, 16'ha5f0}, '{1'b1, 1'b0, 16'h4, 16'h00c3},
		'{1'b0, 1'b1, 16'h5, 16'h00a5}, '{1'b0, 1'b1, 16'h4, 16'h00f0}, '{1'b1, 1'b1, 16'h5, 16'h0},
		'{1'b1, 1'b0, 16'h6, 16'h005a}, '{1'b0, 1'b0, 16'h6, 16'h0f96}};
	logic [15:0] lw [4] = '{16'ha5f0, 16'h00c3, 16'h0f96, 16'h005a};
	logic clk_i, resetn_i, psel, penable, pwrite, treq, twr, thi, tbyte, ram_ack, fa_en, pready, perr;
	logic tbl_ack, stall, ram_req, sbe_irq, trap;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] tea, twd, trd, ram_rdata, ram_addr, ram_first, ram_last, v;
	logic [1:0] fa_op, fa_op_seen;
	logic [21:0] fa_addr, fa_first, fa_last;
	logic [54:0] fa_wdata, fa_rdata, flip;
	logic [2:0] sbe_pri;
	logic e;
	int bad_count, total_checks, cyc, fa_cnt, stall_cnt, ram_cnt, trap_cnt;
	fsp_flash_ctrl #(.PROG_CYC(P_CYC), .ERASE_CYC(E_CYC)) uut (.clk_i(clk_i), .resetn_i(resetn_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(perr), .tbl_req_i(treq), .tbl_write_i(twr),
		.tbl_high_i(thi), .tbl_byte_i(tbyte), .tbl_ea_i(tea), .tbl_wdata_i(twd), .tbl_rdata_o(trd),
		.tbl_ack_o(tbl_ack), .stall_o(stall), .ram_req_o(ram_req), .ram_addr_o(ram_addr), .ram_ack_i(ram_ack),
		.ram_rdata_i(ram_rdata), .fa_en_o(fa_en), .fa_op_o(fa_op), .fa_addr_o(fa_addr), .fa_wdata_o(fa_wdata),
		.fa_rdata_i(fa_rdata), .sbe_irq_o(sbe_irq), .sbe_irq_pri_o(sbe_pri), .hard_trap_o(trap));
	fsp_far_model far (.clk_i(clk_i), .resetn_i(resetn_i), .ram_req_i(ram_req), .ram_addr_i(ram_addr),
		.ram_ack_o(ram_ack), .ram_rdata_o(ram_rdata), .fa_en_i(fa_en), .fa_op_i(fa_op), .fa_addr_i(fa_addr),
		.fa_wdata_i(fa_wdata), .fa_rdata_o(fa_rdata), .flip_i(flip));
	// ==========================================================
	// clock, cycle ceiling and a monitor of flash, ram, stall and trap activity
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
		if (fa_en && fa_op != FSP_FA_READ) begin
			if (fa_cnt == 0) fa_first = fa_addr;
			fa_last = fa_addr;
			fa_op_seen = fa_op;
			fa_cnt++;
		end
		if (ram_req && ram_ack) begin
			if (ram_cnt == 0) ram_first = ram_addr;
			ram_last = ram_addr;
			ram_cnt++;
		end
		stall_cnt += stall;
		trap_cnt += trap;
	end
	// ==========================================================
	// shared checks and bus cycles
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin @(posedge clk_i); end while (pready !== 1'b1);
		r = prdata;
		e = perr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic tbl(input logic w, input logic hi, input logic bm, input logic [15:0] ea, input logic [15:0] d);
		@(posedge clk_i);
		treq <= 1'b1;
		twr <= w;
		thi <= hi;
		tbyte <= bm;
		tea <= ea;
		twd <= d;
		do begin @(posedge clk_i); end while (tbl_ack !== 1'b1);
		v = trd;
		treq <= 1'b0;
	endtask
	// key: 0 none, 1 good, 2 broken by another write
	task automatic do_op(input int key, input logic [31:0] ctl);
		if (key > 0) apb(1'b1, FSP_KEY_OFS, {24'h0, FSP_KEY1});
		if (key == 2) apb(1'b1, FSP_PAGE_OFS, 32'h0);
		if (key > 0) apb(1'b1, FSP_KEY_OFS, {24'h0, FSP_KEY2});
		fa_cnt = 0;
		stall_cnt = 0;
		ram_cnt = 0;
		apb(1'b1, FSP_CTRL_OFS, ctl);
		do begin @(posedge clk_i); end while (stall !== 1'b0);
		repeat (2) @(posedge clk_i);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{resetn_i, psel, penable, pwrite, treq, twr, thi, tbyte} = 8'h00;
		{paddr, pwdata, tea, twd, flip} = 0;
		repeat (10) @(posedge clk_i);
		chk({stall, pready, tbl_ack, fa_en, trap, sbe_irq, ram_req}, 32'h0);
		resetn_i <= 1'b1;
		apb(1'b0, FSP_CTRL_OFS, 32'h0);
		chk(r, 32'h0);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, rr[i].a, rr[i].w);
			chk(e, rr[i].e);
			apb(1'b0, rr[i].a, 32'h0);
			chk(r, rr[i].x);
			chk(e, rr[i].e);
		end
		// refused starts: no key, then a key split by another write
		do_op(0, 32'hc001);
		chk(stall_cnt, 0);
		apb(1'b0, FSP_CTRL_OFS, 32'h0);
		chk(r[FSP_CTRL_SEQERR], 1'b1);
		do_op(2, 32'hc001);
		chk(stall_cnt, 0);
		// double word through the latches in configuration space
		apb(1'b1, FSP_PAGE_OFS, 32'h80);
		for (int i = 0; i < 4; i++) tbl(1'b1, i[0], 1'b0, {14'h0, i[1], 1'b0}, lw[i]);
		apb(1'b1, FSP_ADRH_OFS, 32'h01);
		apb(1'b1, FSP_ADRL_OFS, 32'h0006);
		do_op(1, 32'hc001);
		chk(stall_cnt, P_CYC);
		chk({fa_cnt[7:0], fa_op_seen, fa_first}, {8'h1, FSP_FA_PROG, 22'h4001});
		apb(1'b0, FSP_CTRL_OFS, 32'h0);
		chk(r[FSP_CTRL_START], 1'b0);
		do_op(0, 32'hc001);
		chk(stall_cnt, 0);
		apb(1'b1, FSP_PAGE_OFS, 32'h01);
		for (int i = 0; i < 7; i++) begin
			tbl(1'b0, tr[i].hi, tr[i].bm, tr[i].ea, 16'h0);
			chk(v, tr[i].x);
		end
		// single flip corrected and flagged, then a double flip in the check bits
		trap_cnt = 0;
		flip <= 55'h20;
		tbl(1'b0, 1'b0, 1'b0, 16'h4, 16'h0);
		chk(v, 16'ha5f0);
		tbl(1'b0, 1'b0, 1'b0, 16'h6, 16'h0);
		chk(v, 16'h0f96);
		apb(1'b0, FSP_ECC_OFS, 32'h0);
		chk(r[FSP_ECC_FLAG], 1'b1);
		chk({sbe_irq, sbe_pri, trap_cnt[3:0]}, 8'hf0);
		apb(1'b1, FSP_ECC_OFS, 32'h1c);
		tbl(1'b0, 1'b0, 1'b0, 16'h4, 16'h0);
		chk(v, 16'ha5f0);
		chk(sbe_irq, 1'b0);
		apb(1'b1, FSP_ECC_OFS, 32'h1f);
		apb(1'b0, FSP_ECC_OFS, 32'h0);
		chk({r[FSP_ECC_FLAG], sbe_irq}, 2'h0);
		flip <= 55'h03000000000000;
		tbl(1'b0, 1'b0, 1'b0, 16'h4, 16'h0);
		@(posedge clk_i);
		chk({v, trap_cnt[3:0]}, {16'ha5f0, 4'h1});
		apb(1'b0, FSP_ECC_OFS, 32'h0);
		chk(r[FSP_ECC_FLAG], 1'b0);
		flip <= 55'h0;
		// rows compressed then uncompressed, a page erase between them
		apb(1'b1, FSP_ADRH_OFS, 32'h0);
		apb(1'b1, FSP_ADRL_OFS, 32'h04a6);
		apb(1'b1, FSP_PAGE_OFS, 32'h0);
		for (int cm = 1; cm >= 0; cm--) begin
			apb(1'b1, FSP_SRC_OFS, 32'h0100);
			do_op(1, cm ? 32'hc202 : 32'hc002);
			chk({ram_cnt[15:0], ram_first}, {cm ? 16'd96 : 16'd128, 16'h0100});
			chk(ram_last, cm ? 16'h01be : 16'h01fe);
			chk({fa_cnt[9:0], fa_first}, {10'd32, 22'h120});
			chk(fa_last, 22'h13f);
			tbl(1'b0, 1'b0, 1'b0, 16'h0480, 16'h0);
			chk(v, 16'h0100 ^ 16'h5a3c);
			tbl(1'b0, 1'b1, 1'b0, 16'h0480, 16'h0);
			chk(v, {8'h00, 8'h3e});
			tbl(1'b0, 1'b0, 1'b0, 16'h0482, 16'h0);
			chk(v, 16'h0104 ^ 16'h5a3c);
			tbl(1'b0, 1'b1, 1'b0, 16'h0482, 16'h0);
			chk(v, cm ? 16'h005b : 16'h003a);
			if (cm) begin
				do_op(1, 32'hc003);
				chk({stall_cnt[7:0], fa_op_seen, fa_first}, {E_CYC[7:0], FSP_FA_PAGE, 22'h100});
			end
		end
		do_op(1, 32'hc004);
		chk({stall_cnt[15:0], fa_op_seen}, {E_CYC, FSP_FA_PANEL});
		// reset in mid-erase: start and stall must fall with it, control register back to zero
		apb(1'b1, FSP_KEY_OFS, {24'h0, FSP_KEY1});
		apb(1'b1, FSP_KEY_OFS, {24'h0, FSP_KEY2});
		apb(1'b1, FSP_CTRL_OFS, 32'hc003);
		repeat (2) @(posedge clk_i);
		chk(stall, 1'b1);
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({stall, pready, fa_en, ram_req}, 4'h0);
		resetn_i <= 1'b1;
		apb(1'b0, FSP_CTRL_OFS, 32'h0);
		chk(r, 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
